//--- shared/sslp_defs.svh
`ifndef SSLP_DEFS_SVH
`define SSLP_DEFS_SVH

// serial word framing
`define SSLP_WORD_BITS 24
`define SSLP_BYTE_BITS 8
`define SSLP_BYTES_PER_WORD 3
`define SSLP_ADDR_LSB 0
`define SSLP_ADDR_MSB 2
`define SSLP_ADDR_W 3

// address codes carried in each word
`define SSLP_ADDR_FREQ 3'h0
`define SSLP_ADDR_TIMER 3'h4
`define SSLP_ADDR_STATUS 3'h6

// frequency word payload
`define SSLP_FREQ_LSB 3
`define SSLP_FREQ_MSB 23
`define SSLP_FREQ_W 21

// timer word: which timer, then its count
`define SSLP_TSEL_LSB 3
`define SSLP_TSEL_MSB 4
`define SSLP_TVAL_LSB 5
`define SSLP_TSEL_CUR 2'h0
`define SSLP_TSEL_SWAB 2'h1
`define SSLP_TSEL_SWC 2'h2

// status word: output select
`define SSLP_MSEL_LSB 3
`define SSLP_MSEL_MSB 4

// timer reset counts
`define SSLP_CUR_TIMER_RST 28
`define SSLP_SW_TIMER_RST 35

// rates
`define SSLP_CLK_HZ 100000000
`define SSLP_PFD_HZ 13000000
`define SSLP_PFD_PER_TICK 4
`define SSLP_FAST_BW_FACTOR 4'h8
`define SSLP_FINAL_BW_FACTOR 4'h1
`define SSLP_SER_FMAX_HZ 33000000

`endif

//--- shared/sslp_pkg.sv
package sslp_pkg;

  // what the multiplexed status output shows
  typedef enum logic [1:0] {
    SSLP_MUX_LOW,
    SSLP_MUX_LOCK,
    SSLP_MUX_FASTLOCK,
    SSLP_MUX_HIGH
  } sslp_mux_e;

  // host shifter states
  typedef enum logic [1:0] {
    SSLP_H_IDLE,
    SSLP_H_LOW,
    SSLP_H_SHIFT,
    SSLP_H_LATCH
  } sslp_hstate_e;

endpackage : sslp_pkg

//--- shared/sslp_if.sv
`timescale 1ns/1ns
// three-wire load port plus the status line back to the host
interface sslp_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  logic multiplexed_status_output;

  modport dev (
    input ser_clk,
    input ser_data,
    input load_strobe,
    output multiplexed_status_output
  );

  modport host (
    output ser_clk,
    output ser_data,
    output load_strobe,
    input multiplexed_status_output
  );
endinterface : sslp_if

//--- logic/sslp_dev.sv
`timescale 1ns/1ns
`include "sslp_defs.svh"
module sslp_dev
  import sslp_pkg::*;
#(
  parameter int TIMER_W = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sslp_if.dev port,
  input wire logic lock_detect,
  output logic [`SSLP_FREQ_W-1:0] freq_word_q,
  output logic freq_update_q,
  output logic cp_current_reduced_q,
  output logic [2:0] filter_switch_open_q,
  output logic [3:0] loop_bw_factor_q,
  output logic status_q
);

  localparam int ACC_W = $clog2(`SSLP_CLK_HZ) + 1;
  localparam logic [ACC_W-1:0] PFD_STEP = ACC_W'(`SSLP_PFD_HZ);
  localparam logic [ACC_W-1:0] CLK_WRAP = ACC_W'(`SSLP_CLK_HZ);

  // the timer field must fit above the select bits of the word
  if (TIMER_W < 1 || TIMER_W > `SSLP_WORD_BITS - `SSLP_TVAL_LSB) begin : g_chk
    $error("sslp_dev: TIMER_W out of range");
  end

  // pin sampling: inputs are synchronous, one stage keeps edge detection clean
  logic clk_q, clk_d, clkp_q, clkp_d;
  logic dat_q, dat_d, stb_q, stb_d, stbp_q, stbp_d;
  logic [`SSLP_WORD_BITS-1:0] shreg_q, shreg_d;
  logic clk_rise, stb_rise;

  assign clk_rise = clk_q & ~clkp_q;
  assign stb_rise = stb_q & ~stbp_q;

  always_comb begin
    clk_d = port.ser_clk;
    clkp_d = clk_q;
    dat_d = port.ser_data;
    stb_d = port.load_strobe;
    stbp_d = stb_q;
    shreg_d = shreg_q;
    if (clk_rise) begin
      shreg_d = {shreg_q[`SSLP_WORD_BITS-2:0], dat_q};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_q <= 1'b0;
      clkp_q <= 1'b0;
      dat_q <= 1'b0;
      stb_q <= 1'b1; // strobe idles high, so no false latch after reset
      stbp_q <= 1'b1;
      shreg_q <= '0;
    end else begin
      clk_q <= clk_d;
      clkp_q <= clkp_d;
      dat_q <= dat_d;
      stb_q <= stb_d;
      stbp_q <= stbp_d;
      shreg_q <= shreg_d;
    end
  end

  // register decode on the strobe edge
  logic [`SSLP_ADDR_W-1:0] waddr;
  logic [1:0] tsel;
  logic [TIMER_W-1:0] tval;
  logic [TIMER_W-1:0] cur_t_q, cur_t_d;
  logic [TIMER_W-1:0] sw_t_q [3];
  logic [TIMER_W-1:0] sw_t_d [3];
  logic [1:0] msel_q, msel_d;
  logic [`SSLP_FREQ_W-1:0] freq_d;
  logic upd_d;

  assign waddr = shreg_q[`SSLP_ADDR_MSB:`SSLP_ADDR_LSB];
  assign tsel = shreg_q[`SSLP_TSEL_MSB:`SSLP_TSEL_LSB];
  assign tval = shreg_q[`SSLP_TVAL_LSB +: TIMER_W];

  always_comb begin
    cur_t_d = cur_t_q;
    sw_t_d = sw_t_q;
    msel_d = msel_q;
    freq_d = freq_word_q;
    upd_d = 1'b0;
    if (stb_rise) begin
      case (waddr)
        `SSLP_ADDR_FREQ: begin
          freq_d = shreg_q[`SSLP_FREQ_MSB:`SSLP_FREQ_LSB];
          upd_d = 1'b1;
        end
        `SSLP_ADDR_TIMER: begin
          case (tsel)
            `SSLP_TSEL_CUR: cur_t_d = tval;
            `SSLP_TSEL_SWAB: begin
              sw_t_d[0] = tval;
              sw_t_d[1] = tval;
            end
            `SSLP_TSEL_SWC: sw_t_d[2] = tval;
            default: ; // spare select code, dropped
          endcase
        end
        `SSLP_ADDR_STATUS: msel_d = shreg_q[`SSLP_MSEL_MSB:`SSLP_MSEL_LSB];
        default: ; // unrecognised address leaves every register alone
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_t_q <= TIMER_W'(`SSLP_CUR_TIMER_RST);
      for (int i = 0; i < 3; i++) begin
        sw_t_q[i] <= TIMER_W'(`SSLP_SW_TIMER_RST);
      end
      msel_q <= 2'h0;
      freq_word_q <= '0;
      freq_update_q <= 1'b0;
    end else begin
      cur_t_q <= cur_t_d;
      sw_t_q <= sw_t_d;
      msel_q <= msel_d;
      freq_word_q <= freq_d;
      freq_update_q <= upd_d;
    end
  end

  // comparison-rate enable: a rate accumulator gives exactly 13 MHz on average
  // from 100 MHz, at the cost of one cycle of jitter on each enable
  logic [ACC_W-1:0] acc_q, acc_d;
  logic pfd_en_q, pfd_en_d;
  logic [1:0] pre_q, pre_d;
  logic tick;

  assign tick = pfd_en_q && (pre_q == 2'(`SSLP_PFD_PER_TICK - 1));

  always_comb begin
    acc_d = acc_q + PFD_STEP;
    pfd_en_d = 1'b0;
    if (acc_d >= CLK_WRAP) begin
      acc_d = acc_d - CLK_WRAP;
      pfd_en_d = 1'b1;
    end
    pre_d = pre_q;
    if (upd_d) begin
      pre_d = 2'h0; // timers count from the latch
    end else if (pfd_en_q) begin
      pre_d = pre_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= '0;
      pfd_en_q <= 1'b0;
      pre_q <= 2'h0;
    end else begin
      acc_q <= acc_d;
      pfd_en_q <= pfd_en_d;
      pre_q <= pre_d;
    end
  end

  // fast-lock sequencer: one timer tick is four comparison cycles,
  // so 28 ticks at 13 MHz land near 8.6 us and 35 near 10.8 us
  logic [TIMER_W-1:0] elapsed_q, elapsed_d;
  logic active_q, active_d;
  logic cp_red_d;
  logic [2:0] sw_open_d;
  logic all_open;
  logic [3:0] bw_d;

  for (genvar s = 0; s < 3; s++) begin : g_sw
    // a switch never opens before the current has been reduced
    assign sw_open_d[s] = active_q ? (cp_red_d && (elapsed_q >= sw_t_q[s]))
                                   : filter_switch_open_q[s];
  end

  assign all_open = &sw_open_d;

  always_comb begin
    elapsed_d = elapsed_q;
    active_d = active_q;
    cp_red_d = cp_current_reduced_q;
    if (active_q) begin
      if (tick && elapsed_q != '1) begin
        elapsed_d = elapsed_q + TIMER_W'(1);
      end
      cp_red_d = elapsed_q >= cur_t_q;
      if (all_open) begin
        active_d = 1'b0;
      end
    end
    if (upd_d) begin
      elapsed_d = '0;
      active_d = 1'b1;
      cp_red_d = 1'b0;
    end
    bw_d = active_d ? `SSLP_FAST_BW_FACTOR : `SSLP_FINAL_BW_FACTOR;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      elapsed_q <= '0;
      active_q <= 1'b0;
      cp_current_reduced_q <= 1'b1;
      filter_switch_open_q <= 3'h7;
      loop_bw_factor_q <= `SSLP_FINAL_BW_FACTOR;
    end else begin
      elapsed_q <= elapsed_d;
      active_q <= active_d;
      cp_current_reduced_q <= cp_red_d;
      filter_switch_open_q <= upd_d ? 3'h0 : sw_open_d;
      loop_bw_factor_q <= bw_d;
    end
  end

  // status output multiplexer; lock mode lets a host poll it on a port pin
  logic stat_d;

  always_comb begin
    case (sslp_mux_e'(msel_q))
      SSLP_MUX_LOW: stat_d = 1'b0;
      SSLP_MUX_LOCK: stat_d = lock_detect;
      SSLP_MUX_FASTLOCK: stat_d = active_q;
      SSLP_MUX_HIGH: stat_d = 1'b1;
      default: stat_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= 1'b0;
    end else begin
      status_q <= stat_d;
    end
  end

  assign port.multiplexed_status_output = status_q;

endmodule : sslp_dev

//--- logic/sslp_host.sv
`timescale 1ns/1ns
`include "sslp_defs.svh"
// host end: sends each 24-bit word as three bytes with the strobe held low, then raises the strobe
module sslp_host
  import sslp_pkg::*;
#(
  parameter int HALF_CYC = (`SSLP_CLK_HZ + 2 * `SSLP_SER_FMAX_HZ - 1) / (2 * `SSLP_SER_FMAX_HZ)
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sslp_if.host port,
  input wire logic [`SSLP_WORD_BITS-1:0] word,
  input wire logic word_valid,
  output logic word_ready_q,
  output logic lock_q,
  output logic ser_clk_q,
  output logic ser_data_q,
  output logic load_strobe_q
);

  // a faster serial clock than the device accepts is refused at elaboration
  localparam int MIN_HALF = (`SSLP_CLK_HZ + 2 * `SSLP_SER_FMAX_HZ - 1) / (2 * `SSLP_SER_FMAX_HZ);
  if (HALF_CYC < MIN_HALF) begin : g_chk
    $error("sslp_host: serial clock too fast");
  end

  localparam int HW = $clog2(HALF_CYC + 1);

  sslp_hstate_e st_q, st_d;
  logic [HW-1:0] div_q, div_d;
  logic [`SSLP_WORD_BITS-1:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic sck_d, sdo_d, stb_d, rdy_d;
  logic half; // one-cycle enable at each serial half period

  assign half = (div_q == HW'(HALF_CYC - 1));

  // shifter: data changes while the clock is low, device samples on the rise
  always_comb begin
    st_d = st_q;
    div_d = half ? '0 : div_q + HW'(1);
    sh_d = sh_q;
    bit_d = bit_q;
    byte_d = byte_q;
    sck_d = ser_clk_q;
    sdo_d = ser_data_q;
    stb_d = load_strobe_q;
    rdy_d = word_ready_q;
    case (st_q)
      SSLP_H_IDLE: begin
        div_d = '0;
        if (word_valid && word_ready_q) begin
          sh_d = word;
          rdy_d = 1'b0;
          stb_d = 1'b0;
          st_d = SSLP_H_LOW;
        end
      end
      SSLP_H_LOW: if (half) begin
        sdo_d = sh_q[`SSLP_WORD_BITS-1];
        sh_d = {sh_q[`SSLP_WORD_BITS-2:0], 1'b0};
        bit_d = 3'h0;
        byte_d = 2'h0;
        st_d = SSLP_H_SHIFT;
      end
      SSLP_H_SHIFT: if (half) begin
        sck_d = ~ser_clk_q;
        if (ser_clk_q) begin
          // falling edge: next bit goes out with clock low
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'(`SSLP_BYTE_BITS - 1)) begin
            byte_d = byte_q + 2'h1;
            if (byte_q == 2'(`SSLP_BYTES_PER_WORD - 1)) begin
              st_d = SSLP_H_LATCH;
            end
          end
          sdo_d = sh_q[`SSLP_WORD_BITS-1];
          sh_d = {sh_q[`SSLP_WORD_BITS-2:0], 1'b0};
        end
      end
      SSLP_H_LATCH: if (half) begin
        stb_d = 1'b1;
        rdy_d = 1'b1;
        st_d = SSLP_H_IDLE;
      end
      default: st_d = SSLP_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= SSLP_H_IDLE;
      div_q <= '0;
      sh_q <= '0;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      ser_clk_q <= 1'b0;
      ser_data_q <= 1'b0;
      load_strobe_q <= 1'b1;
      word_ready_q <= 1'b1;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      ser_clk_q <= sck_d;
      ser_data_q <= sdo_d;
      load_strobe_q <= stb_d;
      word_ready_q <= rdy_d;
    end
  end

  // lock polled like a port input pin
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= port.multiplexed_status_output;
    end
  end

  assign port.ser_clk = ser_clk_q;
  assign port.ser_data = ser_data_q;
  assign port.load_strobe = load_strobe_q;

endmodule : sslp_host

//--- testbench/sslp_chk.sv
`timescale 1ns/1ns
// watches the wires of the first link
module sslp_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic multiplexed_status_output
);
  logic clk_prev_q;
  logic [5:0] rise_cnt_q;
  logic [5:0] rise_cnt_d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // clock rises in one frame; saturates so a runaway host stays visible
  always_comb begin
    rise_cnt_d = rise_cnt_q;
    if (load_strobe) begin
      rise_cnt_d = 6'h00;
    end else if (ser_clk && !clk_prev_q && rise_cnt_q != 6'h3f) begin
      rise_cnt_d = rise_cnt_q + 6'h01;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev_q <= 1'b0;
      rise_cnt_q <= 6'h00;
    end else begin
      clk_prev_q <= ser_clk;
      rise_cnt_q <= rise_cnt_d;
    end
  end
  property p_clk_hi;
    $rose(ser_clk) |=> ser_clk;
  endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("clock high too short");
  property p_clk_lo;
    $fell(ser_clk) |=> !ser_clk;
  endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("clock low too short");
  property p_idle;
    $rose(ser_clk) |-> !load_strobe;
  endproperty
  a_idle: assert property (p_idle) else $error("clock with strobe high");
  property p_cnt_max;
    rise_cnt_q <= 6'h18;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("frame too long");
  property p_at24;
    $rose(load_strobe) |-> rise_cnt_q == 6'h18;
  endproperty
  a_at24: assert property (p_at24) else $error("strobe not after bit 24");
  property p_soon;
    ($fell(ser_clk) && rise_cnt_q == 6'h18) |-> ##[1:12] $rose(load_strobe);
  endproperty
  a_soon: assert property (p_soon) else $error("strobe late");
  property p_stable;
    $rose(ser_clk) |-> $stable(ser_data) ##1 $stable(ser_data);
  endproperty
  a_stable: assert property (p_stable) else $error("data moved at rise");
  property p_move;
    $changed(ser_data) |-> !ser_clk;
  endproperty
  a_move: assert property (p_move) else $error("data moved clock high");
endmodule : sslp_chk

//--- testbench/tb_synth_serial_load_port.sv
`timescale 1ns/1ns
`include "sslp_defs.svh"
module tb_synth_serial_load_port;
  logic ref_clk;
  logic sys_rst;
  logic word_valid;
  logic lock_detect;
  logic [23:0] word;
  logic word_ready_q;
  logic lock_q;
  logic [20:0] freq_word_q;
  logic [20:0] freq_b;
  logic freq_update_q;
  logic cp_current_reduced_q;
  logic [2:0] filter_switch_open_q;
  logic [3:0] loop_bw_factor_q;
  logic status_q;
  logic host_clk_pin, host_data_pin, host_strobe_pin;
  int n_fail;
  int check_count;
  int i;
  sslp_if link_if();
  sslp_if fault_if();
  sslp_host sslp_host_inst(.ref_clk, .sys_rst, .port(link_if), .word, .word_valid,
    .word_ready_q, .lock_q, .ser_clk_q(host_clk_pin), .ser_data_q(host_data_pin),
    .load_strobe_q(host_strobe_pin));
  sslp_dev sslp_dev_inst(.ref_clk, .sys_rst, .port(link_if), .lock_detect, .freq_word_q,
    .freq_update_q, .cp_current_reduced_q, .filter_switch_open_q, .loop_bw_factor_q,
    .status_q);
  // second device, fed by hand to shift over-long frames
  sslp_dev fault_sslp_dev_inst(.ref_clk, .sys_rst, .port(fault_if), .lock_detect(1'b0),
    .freq_word_q(freq_b), .freq_update_q(), .cp_current_reduced_q(),
    .filter_switch_open_q(), .loop_bw_factor_q(), .status_q());
  sslp_chk sslp_chk_inst(.ref_clk, .sys_rst, .ser_clk(link_if.ser_clk),
    .ser_data(link_if.ser_data), .load_strobe(link_if.load_strobe),
    .multiplexed_status_output(link_if.multiplexed_status_output));
  // free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // delays jitter by the comparison-enable phase, so they are judged in a window
  task automatic chk_rng(input int g, input int lo, input int hi);
    check_count++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, lo);
    end
  endtask : chk_rng
  function automatic int cyc(input int t);
    return t * `SSLP_PFD_PER_TICK * (`SSLP_CLK_HZ / 100000) / (`SSLP_PFD_HZ / 100000);
  endfunction : cyc
  // hand one word to the host and wait until it has been strobed in
  task automatic send(input logic [23:0] w);
    int n;
    for (n = 0; n < 400 && word_ready_q !== 1'b1; n++) @(negedge ref_clk);
    word = w;
    word_valid = 1'b1;
    @(negedge ref_clk);
    word_valid = 1'b0;
    @(negedge ref_clk);
    for (n = 0; n < 400 && word_ready_q !== 1'b1; n++) @(negedge ref_clk);
  endtask : send
  // latch a frequency, then time the current cut and the last switch opening
  task automatic fast_lock(input logic [20:0] f, input int cur, input int sw);
    int n;
    int ncp;
    ncp = 0;
    send({f, 3'h0});
    repeat (2) @(negedge ref_clk);
    chk({23'h0, freq_update_q}, 24'h1);
    repeat (2) @(negedge ref_clk);
    // the update pulse stands one cycle only, so it must be low again here
    chk({2'h0, freq_update_q, freq_word_q}, {3'h0, f});
    chk({15'h0, cp_current_reduced_q, filter_switch_open_q, loop_bw_factor_q, status_q},
      24'h11);
    for (n = 0; n < 3000 && filter_switch_open_q !== 3'h7; n++) begin
      if (cp_current_reduced_q === 1'b1 && ncp == 0) ncp = n;
      @(negedge ref_clk);
    end
    chk_rng(ncp, cyc(cur) - 12, cyc(cur) + 4);
    chk_rng(n, cyc(sw) - 12, cyc(sw) + 4);
    // bandwidth drops on the edge the last switch opens; status lags a cycle
    chk({19'h0, loop_bw_factor_q, status_q}, 24'h3);
    repeat (2) @(negedge ref_clk);
    chk({19'h0, loop_bw_factor_q, status_q}, 24'h2);
  endtask : fast_lock
  // drive the second link by hand, two cycles per clock level
  task automatic bang(input logic [31:0] v);
    int n;
    fault_if.load_strobe = 1'b0;
    for (n = 31; n >= 0; n--) begin
      fault_if.ser_data = v[n];
      repeat (2) @(negedge ref_clk);
      fault_if.ser_clk = 1'b1;
      repeat (2) @(negedge ref_clk);
      fault_if.ser_clk = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    fault_if.load_strobe = 1'b1;
    fault_if.ser_data = ~fault_if.ser_data; // a released line holds no value
  endtask : bang
  // a hang ends the run as a failure
  initial begin
    #300000;
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    word = 24'h0;
    word_valid = 1'b0;
    lock_detect = 1'b0;
    fault_if.ser_clk = 1'b0;
    fault_if.ser_data = 1'b0;
    fault_if.load_strobe = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({3'h0, freq_word_q}, 24'h0);
    chk({14'h0, cp_current_reduced_q, filter_switch_open_q, loop_bw_factor_q, status_q,
      link_if.load_strobe}, 24'h3c5);
    chk({21'h0, host_clk_pin, host_data_pin, host_strobe_pin}, 24'h1);
    // every status select, with lock toggled under it
    for (i = 0; i < 4; i++) begin
      send({19'h0, i[1:0], 3'h6});
      lock_detect = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk({23'h0, lock_q}, {23'h0, i == 3 || i == 1});
      lock_detect = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk({22'h0, status_q, link_if.multiplexed_status_output}, {22'h0, {2{i == 3}}});
    end
    send({19'h0, 2'h2, 3'h6});
    fast_lock(21'h12345, 28, 35);
    // short timers, then a reserved select and bad addresses that change nothing
    send({11'h0, 8'h05, 2'h0, 3'h4});
    send({11'h0, 8'h0a, 2'h1, 3'h4});
    send({11'h0, 8'h0c, 2'h2, 3'h4});
    send({11'h0, 8'h01, 2'h3, 3'h4});
    send({21'h0abcd, 3'h1});
    send({21'h1fff0, 3'h7});
    repeat (6) @(negedge ref_clk);
    chk({3'h0, freq_word_q}, 24'h12345);
    fast_lock(21'h1fffff, 5, 12);
    fast_lock(21'h000001, 5, 12);
    // over-long frame: only the last 24 bits count
    bang({8'ha5, 21'h15aa5, 3'h0});
    repeat (5) @(negedge ref_clk);
    chk({3'h0, freq_b}, 24'h15aa5);
    report_and_stop();
  end
endmodule : tb_synth_serial_load_port
